/* File: core/gpio_pkg.sv */
package gpio_pkg;

  // pin count and register widths
  localparam int unsigned NPIN      = 2;
  localparam int unsigned AW        = 8;
  localparam int unsigned DW        = 32;

  // register byte offsets
  localparam logic [7:0] OFF_IN     = 8'h00;
  localparam logic [7:0] OFF_OUT    = 8'h04;
  localparam logic [7:0] OFF_OEN    = 8'h08;
  localparam logic [7:0] OFF_IEN    = 8'h0C;
  localparam logic [7:0] OFF_PEN    = 8'h10;
  localparam logic [7:0] OFF_PDIR   = 8'h14;
  localparam logic [7:0] OFF_INTF   = 8'h18;
  localparam logic [7:0] OFF_INTE   = 8'h1C;
  localparam logic [7:0] OFF_EDGE   = 8'h20;
  localparam logic [7:0] OFF_CHAT   = 8'h24;
  localparam logic [7:0] OFF_MODE   = 8'h28;
  localparam logic [7:0] OFF_FNC    = 8'h2C;

  // reset values
  localparam logic [1:0] RST_PIN    = 2'h0;
  localparam logic [3:0] RST_FNC    = 4'h0;
  localparam logic [1:0] RST_CNT    = 2'h0;

  // function code field of one pin
  localparam int unsigned FNC_W     = 2;
  localparam logic [1:0] FNC_CLOCK  = 2'h0;

  // debounce: level must hold this many cycles
  localparam int unsigned DEB_CYC   = 16;
  localparam int unsigned DEB_W     = 5;

  // pin mode
  typedef enum logic [0:0] {
    MODE_GPIO  = 1'b0,
    MODE_PERIPH = 1'b1
  } pin_mode_e;

endpackage : gpio_pkg

/* File: core/pin_debounce.sv */
`timescale 1ns/1ps
module pin_debounce
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_in,
  output logic      clean_out
);

  logic                         level_r;
  logic                         level_nxt;
  logic [gpio_pkg::DEB_W-1:0]   cnt_r;
  logic [gpio_pkg::DEB_W-1:0]   cnt_nxt;

  // count while raw differs; accept the new level only after a full hold
  always_comb
  begin
    level_nxt = level_r;
    cnt_nxt   = '0;
    if (raw_in != level_r)
    begin
      if (cnt_r == gpio_pkg::DEB_W'(gpio_pkg::DEB_CYC - 1))
        level_nxt = raw_in;
      else
        cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_r <= 1'b0;
      cnt_r   <= '0;
    end
    else
    begin
      level_r <= level_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign clean_out = level_r;

  // a glitch shorter than the hold never passes
  a_deb_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(level_r) |-> $past(cnt_r) == gpio_pkg::DEB_W'(gpio_pkg::DEB_CYC - 1))
    else $error("debounce output changed before full hold"); // [R13]

endmodule : pin_debounce

/* File: core/gpio_port.sv */
`timescale 1ns/1ps
// Operation
// [R01] output enabled: pin driven high for data one, low for zero
// [R02] output data writable while disabled; no pin effect until enabled
// [R03] output enable zero releases pin; one lets data drive it
// [R04] input enable zero forces input data to zero
// [R05] output and input enabled: input reads the driven level
// [R06] pull enable one connects the pull resistor
// [R07] pull acts only while output is disabled
// [R08] pull direction one selects pull-up, zero pull-down
// [R09] flag reads one after an event; write one clears, zero keeps
// [R10] interrupt enable one lets the flag request, zero blocks
// [R11] software clears a flag before enabling its interrupt
// [R12] edge bit one: falling edge sets flag; zero: rising edge
// [R13] debounce enable one inserts the filter, zero bypasses it
// [R14] mode bit one gives pin to peripheral, zero to gpio
// [R15] peripheral mode ignores data, enables and pull settings
// [R16] function code zero routes clock block outputs; others unused
// [R17] all fields reset to zero; reserved bits read zero
// [R18] input data is pin level when enabled; zero in peripheral mode
// [R19] interrupt request high while any flag and enable both set
module gpio_port
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        one_second_output,
  input  wire logic        slow_clock_output,
  input  wire logic [1:0]  pad_in,
  output logic      [1:0]  pad_out,
  output logic      [1:0]  pad_oe,
  output logic      [1:0]  pull_up_en,
  output logic      [1:0]  pull_down_en,
  output logic             irq
);

  localparam int unsigned N = gpio_pkg::NPIN;

  logic [N-1:0]   out_r,  out_nxt;
  logic [N-1:0]   oen_r,  oen_nxt;
  logic [N-1:0]   ien_r,  ien_nxt;
  logic [N-1:0]   pen_r,  pen_nxt;
  logic [N-1:0]   pdir_r, pdir_nxt;
  logic [N-1:0]   intf_r, intf_nxt;
  logic [N-1:0]   inte_r, inte_nxt;
  logic [N-1:0]   edge_r, edge_nxt;
  logic [N-1:0]   chat_r, chat_nxt;
  logic [N-1:0]   mode_r, mode_nxt;
  logic [3:0]     fnc_r,  fnc_nxt;
  logic [N-1:0]   prev_r, prev_nxt;
  logic [31:0]    rd_r,   rd_nxt;
  logic [N-1:0]   in_data;
  logic [N-1:0]   filt;
  logic [N-1:0]   sel_in;
  logic [N-1:0]   event_hit;
  logic [N-1:0]   periph_out;
  logic [N-1:0]   periph_oe;
  logic           wr_go;
  logic           rd_go;

  // true when the address names a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == gpio_pkg::OFF_IN)   || (a == gpio_pkg::OFF_OUT)  ||
                (a == gpio_pkg::OFF_OEN)  || (a == gpio_pkg::OFF_IEN)  ||
                (a == gpio_pkg::OFF_PEN)  || (a == gpio_pkg::OFF_PDIR) ||
                (a == gpio_pkg::OFF_INTF) || (a == gpio_pkg::OFF_INTE) ||
                (a == gpio_pkg::OFF_EDGE) || (a == gpio_pkg::OFF_CHAT) ||
                (a == gpio_pkg::OFF_MODE) || (a == gpio_pkg::OFF_FNC);
  endfunction : is_mapped

  // zero wait states: writes land at the access edge, reads are latched at setup
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign wr_go   = psel && penable && pwrite && is_mapped(paddr);
  assign rd_go   = psel && !penable && !pwrite;
  assign prdata  = rd_r;

  // peripheral routing per pin; only code zero has a source
  always_comb
  begin
    periph_out[0] = one_second_output; // [R16]
    periph_out[1] = slow_clock_output; // [R16]
    periph_oe[0]  = (fnc_r[1:0] == gpio_pkg::FNC_CLOCK); // [R16]
    periph_oe[1]  = (fnc_r[3:2] == gpio_pkg::FNC_CLOCK); // [R16]
  end

  // pad drive and pulls; gpio settings ignored in peripheral mode
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (mode_r[i] == gpio_pkg::MODE_PERIPH) // [R14]
      begin
        pad_oe[i]       = periph_oe[i]; // [R15]
        pad_out[i]      = periph_oe[i] && periph_out[i];
        pull_up_en[i]   = 1'b0; // [R15]
        pull_down_en[i] = 1'b0;
      end
      else
      begin
        pad_oe[i]       = oen_r[i]; // [R03]
        pad_out[i]      = oen_r[i] && out_r[i]; // [R01] [R02]
        pull_up_en[i]   = !oen_r[i] && pen_r[i] && pdir_r[i]; // [R06] [R07] [R08]
        pull_down_en[i] = !oen_r[i] && pen_r[i] && !pdir_r[i]; // [R06] [R07] [R08]
      end
    end
  end

  // input path: own drive wins so a loop-back read is exact
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (mode_r[i] || !ien_r[i]) // [R04] [R18]
        in_data[i] = 1'b0;
      else if (oen_r[i])
        in_data[i] = out_r[i]; // [R05]
      else
        in_data[i] = pad_in[i]; // [R18]
    end
  end

  // one filter per pin; bypass keeps zero latency when disabled
  for (genvar g = 0; g < N; g++)
  begin : g_deb
    pin_debounce u_deb
    (
      .pclk      (pclk),
      .presetn   (presetn),
      .raw_in    (in_data[g]),
      .clean_out (filt[g])
    );
  end

  // filter select and edge detection
  always_comb
  begin
    sel_in    = (chat_r & filt) | (~chat_r & in_data); // [R13]
    prev_nxt  = sel_in;
    event_hit = (edge_r & prev_r & ~sel_in)    // [R12]
              | (~edge_r & ~prev_r & sel_in);  // [R12]
  end

  // register writes; a new event beats a same-cycle clear
  always_comb
  begin
    out_nxt  = out_r;
    oen_nxt  = oen_r;
    ien_nxt  = ien_r;
    pen_nxt  = pen_r;
    pdir_nxt = pdir_r;
    inte_nxt = inte_r;
    edge_nxt = edge_r;
    chat_nxt = chat_r;
    mode_nxt = mode_r;
    fnc_nxt  = fnc_r;
    intf_nxt = intf_r;
    if (wr_go)
    begin
      if (paddr == gpio_pkg::OFF_OUT)
        out_nxt = pwdata[N-1:0]; // [R02]
      else if (paddr == gpio_pkg::OFF_OEN)
        oen_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_IEN)
        ien_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_PEN)
        pen_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_PDIR)
        pdir_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_INTF)
        intf_nxt = intf_r & ~pwdata[N-1:0]; // [R09]
      else if (paddr == gpio_pkg::OFF_INTE)
        inte_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_EDGE)
        edge_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_CHAT)
        chat_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_MODE)
        mode_nxt = pwdata[N-1:0];
      else if (paddr == gpio_pkg::OFF_FNC)
        fnc_nxt = pwdata[3:0];
    end
    intf_nxt = intf_nxt | event_hit; // [R09]
  end

  // read mux; reserved bits stay zero
  always_comb
  begin
    rd_nxt = rd_r;
    if (rd_go)
    begin
      rd_nxt = 32'h0000_0000; // [R17]
      if (paddr == gpio_pkg::OFF_IN)
        rd_nxt[N-1:0] = in_data;
      else if (paddr == gpio_pkg::OFF_OUT)
        rd_nxt[N-1:0] = out_r;
      else if (paddr == gpio_pkg::OFF_OEN)
        rd_nxt[N-1:0] = oen_r;
      else if (paddr == gpio_pkg::OFF_IEN)
        rd_nxt[N-1:0] = ien_r;
      else if (paddr == gpio_pkg::OFF_PEN)
        rd_nxt[N-1:0] = pen_r;
      else if (paddr == gpio_pkg::OFF_PDIR)
        rd_nxt[N-1:0] = pdir_r;
      else if (paddr == gpio_pkg::OFF_INTF)
        rd_nxt[N-1:0] = intf_r;
      else if (paddr == gpio_pkg::OFF_INTE)
        rd_nxt[N-1:0] = inte_r;
      else if (paddr == gpio_pkg::OFF_EDGE)
        rd_nxt[N-1:0] = edge_r;
      else if (paddr == gpio_pkg::OFF_CHAT)
        rd_nxt[N-1:0] = chat_r;
      else if (paddr == gpio_pkg::OFF_MODE)
        rd_nxt[N-1:0] = mode_r;
      else if (paddr == gpio_pkg::OFF_FNC)
        rd_nxt[3:0] = fnc_r;
    end
  end

  // all state to zero on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_r  <= gpio_pkg::RST_PIN; // [R17]
      oen_r  <= gpio_pkg::RST_PIN;
      ien_r  <= gpio_pkg::RST_PIN;
      pen_r  <= gpio_pkg::RST_PIN;
      pdir_r <= gpio_pkg::RST_PIN;
      intf_r <= gpio_pkg::RST_PIN;
      inte_r <= gpio_pkg::RST_PIN;
      edge_r <= gpio_pkg::RST_PIN;
      chat_r <= gpio_pkg::RST_PIN;
      mode_r <= gpio_pkg::RST_PIN;
      fnc_r  <= gpio_pkg::RST_FNC;
      prev_r <= gpio_pkg::RST_PIN;
      rd_r   <= 32'h0000_0000;
    end
    else
    begin
      out_r  <= out_nxt;
      oen_r  <= oen_nxt;
      ien_r  <= ien_nxt;
      pen_r  <= pen_nxt;
      pdir_r <= pdir_nxt;
      intf_r <= intf_nxt;
      inte_r <= inte_nxt;
      edge_r <= edge_nxt;
      chat_r <= chat_nxt;
      mode_r <= mode_nxt;
      fnc_r  <= fnc_nxt;
      prev_r <= prev_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // level request gated by enable
  assign irq = |(intf_r & inte_r); // [R10] [R19]

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_out_write;
    wr_go && paddr == gpio_pkg::OFF_OUT;
  endsequence

  sequence s_rise0;
    !edge_r[0] && !chat_r[0] && !prev_r[0] && in_data[0];
  endsequence

  a_out_drive: assert property (s_out_write ##1 (!mode_r[0] && oen_r[0])
    |-> pad_oe[0] && pad_out[0] == $past(pwdata[0]))
    else $error("written data not driven on enabled pin"); // [R01]

  a_hiz_release: assert property (!mode_r[1] && !oen_r[1] |-> !pad_oe[1])
    else $error("disabled pin still driven"); // [R03]

  a_ien_gate: assert property (!ien_r[0] |-> ##1 (rd_r[0] == 1'b0
    || $past(paddr) != gpio_pkg::OFF_IN || !$past(rd_go)))
    else $error("input read nonzero with input disabled"); // [R04]

  a_pull_off: assert property (pad_oe[0] |-> !pull_up_en[0] && !pull_down_en[0])
    else $error("pull active while pin driven"); // [R07]

  a_flag_rise: assert property (s_rise0 |=> intf_r[0])
    else $error("rising edge did not set flag"); // [R12]

  a_flag_clear: assert property (wr_go && paddr == gpio_pkg::OFF_INTF && pwdata[1]
    && !event_hit[1] |=> !intf_r[1])
    else $error("write one did not clear flag"); // [R09]

  a_flag_keep: assert property (wr_go && paddr == gpio_pkg::OFF_INTF && !pwdata[0]
    && intf_r[0] |=> intf_r[0])
    else $error("write zero disturbed flag"); // [R09]

  a_irq_level: assert property (irq == ((intf_r[0] && inte_r[0]) || (intf_r[1] && inte_r[1])))
    else $error("interrupt level mismatch"); // [R19]

  a_periph_route: assert property (mode_r[1] && fnc_r[3:2] == gpio_pkg::FNC_CLOCK
    |-> pad_oe[1] && pad_out[1] == slow_clock_output)
    else $error("slow clock not routed"); // [R16]

  a_reserved_zero: assert property (rd_go ##1 1'b1 |-> rd_r[31:4] == 28'h000_0000)
    else $error("reserved read bits nonzero"); // [R17]

  // falling edge on pin one when that edge is selected
  sequence s_fall1;
    edge_r[1] && !chat_r[1] && prev_r[1] && !in_data[1];
  endsequence

  a_flag_fall: assert property (s_fall1 |=> intf_r[1])
    else $error("falling edge did not set flag"); // [R12]

  a_pull_dir: assert property (!mode_r[0] && !oen_r[0] && pen_r[0]
    |-> pull_up_en[0] == pdir_r[0] && pull_down_en[0] == !pdir_r[0])
    else $error("pull direction wrong"); // [R08]

  a_periph_quiet: assert property (mode_r[0] |-> !pull_up_en[0] && !pull_down_en[0]
    && pad_oe[0] == (fnc_r[1:0] == gpio_pkg::FNC_CLOCK))
    else $error("gpio settings leak into peripheral pin"); // [R15]

  a_periph_input: assert property (mode_r[1] |-> !in_data[1])
    else $error("peripheral pin input not zero"); // [R18]

  a_loop_back: assert property (!mode_r[1] && oen_r[1] && ien_r[1] |-> in_data[1] == out_r[1])
    else $error("loop-back read differs from drive"); // [R05]

  a_deb_path: assert property (chat_r[0] |-> sel_in[0] == filt[0])
    else $error("filter not in input path"); // [R13]

  a_pin_drive1: assert property (!mode_r[1] && oen_r[1] |-> pad_oe[1] && pad_out[1] == out_r[1])
    else $error("enabled pin not driving its data"); // [R01]

endmodule : gpio_port

/* File: test/pin_board.sv */
`timescale 1ns/1ps
module pin_board
(
  input  wire logic       pclk,
  input  wire logic [1:0] pad_out,
  input  wire logic [1:0] pad_oe,
  input  wire logic [1:0] pull_up_en,
  input  wire logic [1:0] pull_down_en,
  input  wire logic [1:0] ext_en,
  input  wire logic [1:0] ext_val,
  output logic      [1:0] pad_in
);
  logic [1:0] float_r = 2'h1;

  // a floating pin wanders each cycle so a stale level never passes by luck
  always_ff @(posedge pclk)
    float_r <= ~float_r;

  // wire level: device drive wins, then the board, then a pull, else floating
  always_comb
    for (int i = 0; i < 2; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                  pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : float_r[i];
endmodule : pin_board

/* File: test/tb_two_pin_gpio_port_group.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_two_pin_gpio_port_group;
  logic        pclk, presetn, psel, penable, pwrite, one_sec, slow_clk, pstb;
  logic        pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  pad_in, pad_out, pad_oe, pu, pd, ext_en, ext_val;
  logic [32:0] q_rd[$];
  logic [8:0]  q_pin[$];
  logic [32:0] ex_rd;
  logic [8:0]  ex_pin;
  int          err_count, n_checks, seed, r;

  gpio_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .one_second_output(one_sec), .slow_clock_output(slow_clk),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pu),
    .pull_down_en(pd), .irq(irq));

  pin_board board_u (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pu),
    .pull_down_en(pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // 25 MHz
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // one apb transfer; entered just after a rising edge, leaves one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_count++;
      stop_test();
    end
    @(posedge pclk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    q_rd.push_back({er, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // expected {oe, out, pull up, pull down, irq}
  task automatic pins(input logic [8:0] e);
    q_pin.push_back(e);
    pstb <= 1'b1;
    @(posedge pclk);
    pstb <= 1'b0;
    @(posedge pclk);
  endtask : pins

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // every register zero, unmapped place refused, pins quiet
  task automatic chk_regs();
    for (int i = 0; i < 12; i++)
      rd(gpio_pkg::OFF_IN + 8'(4 * i), 32'h0000_0000);
    rd(8'h30, 32'h0000_0000, 1'b1);
    pins(9'h000);
  endtask : chk_regs

  // watcher: takes the oldest note whenever a result appears
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && q_rd.size() > 0)
    begin
      ex_rd = q_rd.pop_front();
      `CHK({pslverr, prdata}, ex_rd)
    end
    if (pstb && q_pin.size() > 0)
    begin
      ex_pin = q_pin.pop_front();
      `CHK({pad_oe, pad_out, pu, pd, irq}, ex_pin)
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    one_sec = 1'b0;
    slow_clk = 1'b0;
    pstb = 1'b0;
    ext_en = 2'h0;
    ext_val = 2'h0;
    err_count = 0;
    n_checks = 0;
    seed = 32'h1c5e_4907;
    do_reset();
    chk_regs();
    $display("test 1 reset values done");
    r = $random(seed);
    wr(gpio_pkg::OFF_OUT, r);
    pins(9'h000);
    rd(gpio_pkg::OFF_OUT, {30'h0, r[1:0]});
    wr(gpio_pkg::OFF_OEN, 32'h0000_0003);
    pins({2'h3, r[1:0], 5'h00});
    ext_en <= 2'h3;
    ext_val <= ~r[1:0];
    wr(gpio_pkg::OFF_IEN, 32'h0000_0003);
    rd(gpio_pkg::OFF_IN, {30'h0, r[1:0]});
    $display("test 2 output drive done");
    wr(gpio_pkg::OFF_OEN, 32'h0000_0000);
    wr(gpio_pkg::OFF_IEN, 32'h0000_0001);
    ext_val <= 2'h3;
    rd(gpio_pkg::OFF_IN, 32'h0000_0001);
    ext_en <= 2'h0;
    wr(gpio_pkg::OFF_PEN, 32'h0000_0003);
    wr(gpio_pkg::OFF_PDIR, 32'h0000_0001);
    pins({4'h0, 2'h1, 2'h2, 1'b0});
    rd(gpio_pkg::OFF_IN, 32'h0000_0001);
    wr(gpio_pkg::OFF_OEN, 32'h0000_0001);
    pins({2'h1, 1'b0, r[0], 2'h0, 2'h2, 1'b0});
    wr(gpio_pkg::OFF_OEN, 32'h0000_0000);
    wr(gpio_pkg::OFF_PEN, 32'h0000_0000);
    $display("test 3 input and pulls done");
    ext_en <= 2'h3;
    ext_val <= 2'h0;
    wr(gpio_pkg::OFF_IEN, 32'h0000_0003);
    wr(gpio_pkg::OFF_EDGE, 32'h0000_0002);
    wr(gpio_pkg::OFF_INTF, 32'h0000_0003);
    wr(gpio_pkg::OFF_INTE, 32'h0000_0003);
    rd(gpio_pkg::OFF_INTF, 32'h0000_0000);
    ext_val <= 2'h3;
    repeat (2) @(posedge pclk);
    rd(gpio_pkg::OFF_INTF, 32'h0000_0001);
    pins(9'h001);
    wr(gpio_pkg::OFF_INTF, 32'h0000_0002);
    rd(gpio_pkg::OFF_INTF, 32'h0000_0001);
    wr(gpio_pkg::OFF_INTF, 32'h0000_0001);
    rd(gpio_pkg::OFF_INTF, 32'h0000_0000);
    pins(9'h000);
    ext_val <= 2'h0;
    repeat (2) @(posedge pclk);
    rd(gpio_pkg::OFF_INTF, 32'h0000_0002);
    wr(gpio_pkg::OFF_INTE, 32'h0000_0001);
    pins(9'h000);
    wr(gpio_pkg::OFF_INTE, 32'h0000_0002);
    pins(9'h001);
    wr(gpio_pkg::OFF_INTE, 32'h0000_0000);
    $display("test 4 interrupts done");
    // filter on pin 0 only; switching it may raise one event, so settle first
    wr(gpio_pkg::OFF_EDGE, 32'h0000_0000);
    wr(gpio_pkg::OFF_CHAT, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    wr(gpio_pkg::OFF_INTF, 32'h0000_0003);
    ext_val <= 2'h3;
    repeat (8) @(posedge pclk);
    ext_val <= 2'h0;
    repeat (20) @(posedge pclk);
    rd(gpio_pkg::OFF_INTF, 32'h0000_0002);
    ext_val <= 2'h1;
    repeat (20) @(posedge pclk);
    rd(gpio_pkg::OFF_INTF, 32'h0000_0003);
    $display("test 5 debounce done");
    wr(gpio_pkg::OFF_PEN, 32'h0000_0003);
    one_sec <= r[2];
    slow_clk <= r[3];
    wr(gpio_pkg::OFF_MODE, 32'h0000_0003);
    pins({2'h3, r[3], r[2], 5'h00});
    rd(gpio_pkg::OFF_IN, 32'h0000_0000);
    for (int c = 1; c < 4; c++)
    begin
      wr(gpio_pkg::OFF_FNC, 32'(c * 5));
      pins(9'h000);
    end
    $display("test 6 peripheral mode done");
    do_reset();
    chk_regs();
    $display("test 7 second reset done");
    stop_test();
  end
endmodule : tb_two_pin_gpio_port_group
